// File: rtl/dtc_pkg.sv
// Package: register map, field layout and encodings of the dual timer control block
package dtc_pkg;
	// Register word indices (printed offsets 0x1A/0x1B are not word multiples: kept as index)
	localparam logic [7:0] IDX_T3_CTRL = 8'h1A;
	localparam logic [7:0] IDX_T4_CTRL = 8'h1B;
	localparam logic [7:0] IDX_T3_PERIOD = 8'h1C;
	localparam logic [7:0] IDX_T3_PULSE = 8'h1D;
	localparam logic [7:0] IDX_T4_PERIOD = 8'h1E;
	localparam logic [7:0] IDX_T4_PULSE = 8'h1F;
	localparam logic [7:0] IDX_MISC = 8'h20;
	localparam logic [7:0] IDX_STATUS = 8'h21;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] TREG_RESET = 8'h00;
	// Control field positions
	localparam int FF_BIT = 7;
	localparam int CK_HI = 6;
	localparam int CK_LO = 4;
	localparam int START_BIT = 3;
	localparam int MODE_HI = 2;
	localparam int MODE_LO = 0;
	// Misc register bits
	localparam int MISC_PSRC_BIT = 0;
	localparam int MISC_SLOW_BIT = 1;
	typedef enum logic [2:0] {
		DTC_CK_DIV11 = 3'b000,
		DTC_CK_DIV7 = 3'b001,
		DTC_CK_DIV5 = 3'b010,
		DTC_CK_DIV3 = 3'b011,
		DTC_CK_FS = 3'b100,
		DTC_CK_DIV1 = 3'b101,
		DTC_CK_FC = 3'b110,
		DTC_CK_PIN = 3'b111
	} dtc_clk_t;
	typedef enum logic [2:0] {
		DTC_M_TIMER8 = 3'b000,
		DTC_M_PDO8 = 3'b001,
		DTC_M_PWM8 = 3'b010,
		DTC_M_CASCADE = 3'b011,
		DTC_M_TIMER16 = 3'b100,
		DTC_M_WARMUP = 3'b101,
		DTC_M_PWM16 = 3'b110,
		DTC_M_PPG16 = 3'b111
	} dtc_mode_t;
endpackage

// File: rtl/dtc_regs_if.sv
// Interface: one timer unit's decoded register settings, clock sources and count tick
`timescale 1ns/1ps
`default_nettype none
interface dtc_regs_if;
	logic [2:0] ck_sel;
	logic [2:0] mode;
	logic running;
	logic [7:0] prescale;
	logic fs_tick;
	logic pin_tick;
	logic psrc;
	logic slow;
	logic tick;
	modport sel (input ck_sel, input prescale, input fs_tick, input pin_tick, input psrc,
		input slow, output tick);
	modport top (output ck_sel, output prescale, output fs_tick, output pin_tick, output psrc,
		output slow, input tick, output mode, output running);
endinterface
`default_nettype wire

// File: rtl/dtc_clk_select.sv
// Source clock selector: turns the 3-bit select into a one-cycle count tick
`timescale 1ns/1ps
`default_nettype none
module dtc_clk_select (
	input wire logic pclk,
	input wire logic presetn,
	dtc_regs_if.sel s
);
	logic [7:0] pre_q;
	logic [2:0] fs_div;
	logic fs8_tick;
	wire [7:0] rise = s.prescale & ~pre_q;
	// Low-speed or prescaler-source bit swaps fc/2^11 for fs/2^3
	wire use_fs8 = s.psrc | s.slow;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q <= 8'h00;
			fs_div <= 3'h0;
		end else begin
			pre_q <= s.prescale;
			if (s.fs_tick) begin
				fs_div <= fs_div + 3'h1;
			end
		end
	end
	assign fs8_tick = s.fs_tick && (fs_div == 3'h7);
	always_comb begin
		case (dtc_pkg::dtc_clk_t'(s.ck_sel))
			dtc_pkg::DTC_CK_DIV11: s.tick = use_fs8 ? fs8_tick : rise[7];
			dtc_pkg::DTC_CK_DIV7: s.tick = rise[6];
			dtc_pkg::DTC_CK_DIV5: s.tick = rise[4];
			dtc_pkg::DTC_CK_DIV3: s.tick = rise[2];
			dtc_pkg::DTC_CK_FS: s.tick = s.fs_tick;
			dtc_pkg::DTC_CK_DIV1: s.tick = rise[0];
			dtc_pkg::DTC_CK_FC: s.tick = 1'b1;
			dtc_pkg::DTC_CK_PIN: s.tick = s.pin_tick;
			default: s.tick = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// File: rtl/dtc_timer_ctrl.sv
// Top: dual 8-bit timer control, cascade steering and APB register file
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] fc_prescale,
	input wire logic fs_clk,
	input wire logic t3_count_pin,
	input wire logic t4_count_pin,
	output logic [7:0] t3_count,
	output logic [7:0] t4_count,
	output logic t3_flipflop,
	output logic t4_flipflop,
	output logic [2:0] active_mode,
	output logic cascade
);
	logic [7:0] timer3_control;
	logic [7:0] timer4_control;
	logic [7:0] t3_period;
	logic [7:0] t3_pulse;
	logic [7:0] t4_period;
	logic [7:0] t4_pulse;
	// Misc: prescaler-source and low-speed bits
	logic [1:0] misc;
	logic [1:0] fs_sync;
	logic fs_q;
	logic [1:0] p3_sync;
	logic [1:0] p4_sync;
	logic p3_q;
	logic p4_q;
	// One bundle per unit feeds its clock selector
	dtc_regs_if u3 ();
	dtc_regs_if u4 ();

	function automatic logic hit(input logic [31:0] a, input logic [7:0] idx);
		return a == {22'h0, idx, 2'b00};
	endfunction

	wire wr = psel && penable && pwrite;
	wire sel_c3 = hit(paddr, dtc_pkg::IDX_T3_CTRL);
	wire sel_c4 = hit(paddr, dtc_pkg::IDX_T4_CTRL);
	wire sel_p3 = hit(paddr, dtc_pkg::IDX_T3_PERIOD);
	wire sel_w3 = hit(paddr, dtc_pkg::IDX_T3_PULSE);
	wire sel_p4 = hit(paddr, dtc_pkg::IDX_T4_PERIOD);
	wire sel_w4 = hit(paddr, dtc_pkg::IDX_T4_PULSE);
	wire sel_ms = hit(paddr, dtc_pkg::IDX_MISC);
	wire sel_st = hit(paddr, dtc_pkg::IDX_STATUS);
	wire mapped = sel_c3 | sel_c4 | sel_p3 | sel_w3 | sel_p4 | sel_w4 | sel_ms | sel_st;

	wire [2:0] t3_mode = timer3_control[dtc_pkg::MODE_HI:dtc_pkg::MODE_LO];
	wire [2:0] t4_mode = timer4_control[dtc_pkg::MODE_HI:dtc_pkg::MODE_LO];
	wire t3_start = timer3_control[dtc_pkg::START_BIT];
	wire t4_start = timer4_control[dtc_pkg::START_BIT];
	wire t3_flipflop_ctl = timer3_control[dtc_pkg::FF_BIT];
	wire t4_flipflop_ctl = timer4_control[dtc_pkg::FF_BIT];
	// Cascade only when unit 3 holds 011 and unit 4 picks a 1xx mode
	assign cascade = (t3_mode == dtc_pkg::DTC_M_CASCADE) && t4_mode[2];
	assign active_mode = cascade ? t4_mode : t3_mode;
	wire run3 = cascade ? t4_start : t3_start;
	wire run4 = t4_start;
	wire pwm3 = (active_mode == dtc_pkg::DTC_M_PWM8) || (active_mode == dtc_pkg::DTC_M_PWM16);
	wire pwm4 = (t4_mode == dtc_pkg::DTC_M_PWM8) || (t4_mode == dtc_pkg::DTC_M_PWM16);
	// Period writes ignored while running; pulse writes while running allowed in PWM only
	wire ok_p3 = !run3;
	wire ok_w3 = !run3 || pwm3;
	// In cascade unit 3 runs off unit 4's start, so one run flag covers both bytes
	wire ok_p4 = !run4;
	// Unit 4 mode decides PWM for both single and cascaded use
	wire ok_w4 = !run4 || pwm4;

	// Both units share the prescaler and fs; the cascade takes unit 3's select
	assign u3.ck_sel = timer3_control[dtc_pkg::CK_HI:dtc_pkg::CK_LO];
	assign u4.ck_sel = timer4_control[dtc_pkg::CK_HI:dtc_pkg::CK_LO];
	assign u3.prescale = fc_prescale;
	assign u4.prescale = fc_prescale;
	assign u3.fs_tick = fs_sync[1] & ~fs_q;
	assign u4.fs_tick = fs_sync[1] & ~fs_q;
	assign u3.pin_tick = p3_sync[1] & ~p3_q;
	assign u4.pin_tick = p4_sync[1] & ~p4_q;
	assign u3.psrc = misc[dtc_pkg::MISC_PSRC_BIT];
	assign u4.psrc = misc[dtc_pkg::MISC_PSRC_BIT];
	assign u3.slow = misc[dtc_pkg::MISC_SLOW_BIT];
	assign u4.slow = misc[dtc_pkg::MISC_SLOW_BIT];
	assign u3.mode = t3_mode;
	assign u4.mode = t4_mode;
	assign u3.running = run3;
	assign u4.running = run4;

	dtc_clk_select sel3 (
		.pclk(pclk),
		.presetn(presetn),
		.s(u3.sel)
	);
	dtc_clk_select sel4 (
		.pclk(pclk),
		.presetn(presetn),
		.s(u4.sel)
	);

	// Counter compares against period; ends of period give overflow
	wire t3_ovf = u3.tick && (t3_count == t3_period);
	wire t4_step = cascade ? t3_ovf : u4.tick;
	wire t4_ovf = t4_step && (t4_count == t4_period);

	// Two flops before any edge detect: fs and the pins are asynchronous
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fs_sync <= 2'h0;
			fs_q <= 1'b0;
			p3_sync <= 2'h0;
			p4_sync <= 2'h0;
			p3_q <= 1'b0;
			p4_q <= 1'b0;
		end else begin
			fs_sync <= {fs_sync[0], fs_clk};
			fs_q <= fs_sync[1];
			p3_sync <= {p3_sync[0], t3_count_pin};
			p4_sync <= {p4_sync[0], t4_count_pin};
			p3_q <= p3_sync[1];
			p4_q <= p4_sync[1];
		end
	end

	// Register file: control registers always writable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer3_control <= dtc_pkg::CTRL_RESET;
			timer4_control <= dtc_pkg::CTRL_RESET;
			t3_period <= dtc_pkg::TREG_RESET;
			t3_pulse <= dtc_pkg::TREG_RESET;
			t4_period <= dtc_pkg::TREG_RESET;
			t4_pulse <= dtc_pkg::TREG_RESET;
			misc <= 2'h0;
		end else if (wr) begin
			if (sel_c3) timer3_control <= pwdata[7:0];
			if (sel_c4) timer4_control <= pwdata[7:0];
			if (sel_p3 && ok_p3) t3_period <= pwdata[7:0];
			if (sel_w3 && ok_w3) t3_pulse <= pwdata[7:0];
			if (sel_p4 && ok_p4) t4_period <= pwdata[7:0];
			if (sel_w4 && ok_w4) t4_pulse <= pwdata[7:0];
			if (sel_ms) misc <= pwdata[1:0];
		end
	end

	// Counters: stopped units sit at zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t3_count <= 8'h00;
			t4_count <= 8'h00;
		end else begin
			if (!run3) t3_count <= 8'h00;
			else if (t3_ovf) t3_count <= 8'h00;
			else if (u3.tick) t3_count <= t3_count + 8'h01;
			if (!run4) t4_count <= 8'h00;
			else if (t4_ovf) t4_count <= 8'h00;
			else if (t4_step) t4_count <= t4_count + 8'h01;
		end
	end

	// Output flip-flops preset from control bit while stopped, toggle on overflow except unit 3 in cascade
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t3_flipflop <= 1'b0;
			t4_flipflop <= 1'b0;
		end else begin
			if (!run3) t3_flipflop <= cascade ? t4_flipflop_ctl : t3_flipflop_ctl;
			else if (t3_ovf && !cascade) t3_flipflop <= ~t3_flipflop;
			if (!run4) t4_flipflop <= t4_flipflop_ctl;
			else if (t4_ovf) t4_flipflop <= ~t4_flipflop;
		end
	end

	// Status is read-only; writes to it are dropped
	wire [7:0] status = {3'h0, cascade, t4_flipflop, t3_flipflop, run4, run3};
	wire [7:0] rsel = sel_c3 ? timer3_control : sel_c4 ? timer4_control :
		sel_p3 ? t3_period : sel_w3 ? t3_pulse : sel_p4 ? t4_period :
		sel_w4 ? t4_pulse : sel_ms ? {6'h00, misc} : sel_st ? status : 8'h00;

	always_ff @(posedge pclk or negedge presetn) begin
		// Latched in setup so the access phase sees a settled word
		if (!presetn) prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite) prdata <= {24'h00_0000, rsel};
	end
	// Zero wait states: every access ends in its first access cycle
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
endmodule
`default_nettype wire

// File: sim/dtc_timer_ctrl_monitor.sv
// Checker: port-level relations of the dual timer control block
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_ctrl_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic [7:0] t3_count,
	input wire logic [7:0] t4_count,
	input wire logic t3_flipflop,
	input wire logic [2:0] active_mode,
	input wire logic cascade
);
	logic [7:0] c3, c4;
	logic acc, wr, cas, run3, run4;
	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign cas = c3[2:0] == 3'h3 && c4[2];
	assign run3 = cas ? c4[3] : c3[3];
	assign run4 = c4[3];
	// Shadow copies: control writes are never refused
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			c3 <= 8'h00;
			c4 <= 8'h00;
		end else begin
			if (wr && paddr == 32'h68) c3 <= pwdata[7:0];
			if (wr && paddr == 32'h6C) c4 <= pwdata[7:0];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Two settled cycles, since counters and flip-flops are registered
	sequence s_quiet3;
		(!run3 && $stable(c3) && $stable(c4)) [*2];
	endsequence
	sequence s_quiet4;
		(!run4 && $stable(c4)) [*2];
	endsequence
	ctrl3_read_a: assert property (acc && !pwrite && paddr == 32'h68 |-> prdata == {24'h0, c3})
		else $error("unit 3 control readback wrong");
	ctrl4_read_a: assert property (acc && !pwrite && paddr == 32'h6C |-> prdata == {24'h0, c4})
		else $error("unit 4 control readback wrong");
	stop3_clear_a: assert property (s_quiet3 |-> t3_count == 8'h00)
		else $error("unit 3 count not cleared");
	stop4_clear_a: assert property (s_quiet4 |-> t4_count == 8'h00)
		else $error("unit 4 count not cleared");
	ff_preset_a: assert property (s_quiet3 |-> t3_flipflop == (cas ? c4[7] : c3[7]))
		else $error("unit 3 flip-flop preset wrong");
	cascade_dec_a: assert property (cascade == cas)
		else $error("cascade decode wrong");
	mode_route_a: assert property (active_mode == (cas ? c4[2:0] : c3[2:0]))
		else $error("active mode routing wrong");
	unmapped_err_a: assert property (acc && paddr[1:0] == 2'h0 |->
		pslverr == !(paddr inside {[32'h68:32'h84]}))
		else $error("slave error flag wrong");
endmodule
bind dtc_timer_ctrl dtc_timer_ctrl_monitor i_mon (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pslverr, .t3_count, .t4_count, .t3_flipflop, .active_mode,
	.cascade);
`default_nettype wire

// File: sim/tb_dual_8bit_timer_control.sv
// Testbench: register-level tests of the dual timer control block
`timescale 1ns/1ps
`default_nettype none
module tb_dual_8bit_timer_control;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fs_clk;
	logic t3_count_pin, t4_count_pin, t3_flipflop, t4_flipflop, cascade;
	logic [31:0] paddr, pwdata, prdata;
	logic [7:0] fc_prescale, t3_count, t4_count;
	logic [2:0] active_mode;
	int miscompares = 0;
	int checks_done = 0;
	int cyc = 0;
	dtc_timer_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .fc_prescale, .fs_clk, .t3_count_pin, .t4_count_pin, .t3_count,
		.t4_count, .t3_flipflop, .t4_flipflop, .active_mode, .cascade);
	initial begin
		pclk = 0;
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) fc_prescale <= fc_prescale + 8'h01;
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			end_sim();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1;
		paddr <= a;
		pwrite <= 1;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
		// Let the landing edge's updates settle before anyone looks
		#1;
	endtask
	task automatic rc(input logic [31:0] a, input logic [7:0] e);
		logic [31:0] d;
		@(posedge pclk);
		psel <= 1;
		paddr <= a;
		pwrite <= 0;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		d = prdata;
		psel <= 0;
		penable <= 0;
		chk($sformatf("reg %h", a), d, {24'h0, e});
	endtask
	task automatic pls(input int n);
		repeat (n) begin
			@(posedge pclk) t3_count_pin <= 1;
			repeat (4) @(posedge pclk);
			t3_count_pin <= 0;
			repeat (4) @(posedge pclk);
		end
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, fc_prescale, fs_clk} = '0;
		{t3_count_pin, t4_count_pin} = '0;
		presetn = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1;
		for (int i = 0; i < 6; i++) rc(32'h68 + 4 * i, 8'h00);
		for (int m = 0; m < 4; m++) begin
			wr(32'h68, 8'hB0 | 8'(m));
			rc(32'h68, 8'hB0 | 8'(m));
			chk("active_mode", active_mode, m);
		end
		for (int m = 4; m < 8; m++) begin
			wr(32'h6C, 8'(m));
			chk("cascade", cascade, 1);
			chk("active_mode", active_mode, m);
		end
		wr(32'h6C, 8'h00);
		wr(32'h70, 8'hFF);
		// Idle fs and pin sources must leave the count at zero
		for (int k = 0; k < 8; k++) begin
			wr(32'h68, 8'h08 | 8'(k << 4));
			repeat (600) @(posedge pclk);
			chk("t3 ticking", t3_count != 8'h00, k != 4 && k != 7);
			wr(32'h68, 8'(k << 4));
			repeat (2) @(posedge pclk);
			chk("t3_count", t3_count, 0);
		end
		// Prescaler-source, then low-speed: select 000 counts every eighth fs rise
		for (int v = 1; v < 3; v++) begin
			wr(32'h80, 8'(v));
			wr(32'h68, 8'h08);
			repeat (16) begin
				@(posedge pclk) fs_clk <= 1;
				repeat (3) @(posedge pclk);
				fs_clk <= 0;
				repeat (3) @(posedge pclk);
			end
			chk("t3 prescaler fs", t3_count, 2);
			wr(32'h68, 8'h00);
		end
		wr(32'h80, 8'h00);
		wr(32'h68, 8'h78);
		pls(3);
		chk("t3 pin count", t3_count, 3);
		wr(32'h70, 8'h10);
		rc(32'h70, 8'hFF);
		wr(32'h74, 8'h22);
		rc(32'h74, 8'h00);
		wr(32'h68, 8'h70);
		wr(32'h68, 8'h7A);
		wr(32'h74, 8'h22);
		rc(32'h74, 8'h22);
		wr(32'h68, 8'h72);
		wr(32'h70, 8'h01);
		rc(32'h70, 8'h01);
		wr(32'h6C, 8'h08);
		wr(32'h78, 8'h33);
		rc(32'h78, 8'h00);
		wr(32'h7C, 8'h44);
		rc(32'h7C, 8'h00);
		wr(32'h6C, 8'h00);
		wr(32'h6C, 8'h0E);
		wr(32'h7C, 8'h44);
		rc(32'h7C, 8'h44);
		wr(32'h6C, 8'h06);
		wr(32'h78, 8'hFF);
		// Upper byte on fc would race ahead if it ignored the overflow source
		wr(32'h68, 8'h73);
		wr(32'h6C, 8'hEC);
		pls(4);
		chk("t3_count", t3_count, 0);
		chk("t4_count", t4_count, 2);
		wr(32'h6C, 8'hE4);
		repeat (2) @(posedge pclk);
		chk("t3_flipflop", t3_flipflop, 1);
		chk("t4_flipflop", t4_flipflop, 1);
		rc(32'h100, 8'h00);
		end_sim();
	end
endmodule
`default_nettype wire
